//--- hw/flash_pm_regs.svh
// Opcodes, status word layout and timing figures for the power sequencer
`ifndef FLASH_PM_REGS_SVH
`define FLASH_PM_REGS_SVH

`define OPC_STATUS_READ 8'hd7
`define OPC_SLEEP_ENTER 8'hb9
`define OPC_SLEEP_RESUME 8'hab
`define OPC_DEEP_ENTER 8'h79

`define STAT_W 16
`define STAT_RESET 16'h0000
`define B1_READY 15
`define B1_COMPARE 14
`define B1_CAP_HI 13
`define B1_CAP_LO 10
`define B1_PROTECT 9
`define B1_PAGE_BIN 8
`define B2_READY 7
`define B2_RSVD6 6
`define B2_FAIL 5
`define B2_RSVD4 4
`define B2_LOCK_OK 3
`define B2_HOLD_BUF2 2
`define B2_HOLD_BUF1 1
`define B2_ERASE_HALT 0

`define CORE_CLK_MHZ 200
`define SLEEP_ENTRY_TIME_NS 3000
`define SLEEP_EXIT_TIME_NS 8000
`define DEEP_SLEEP_ENTRY_TIME_NS 3000
`define DEEP_SLEEP_EXIT_TIME_NS 120000
`define WAKE_PULSE_WIDTH_NS 20

// Longest times round down, least times round up, never below one cycle
`define NS_TO_CYC_DN(ns) ((((ns) * `CORE_CLK_MHZ) / 1000) < 1 ? 1 : \
  (((ns) * `CORE_CLK_MHZ) / 1000))
`define NS_TO_CYC_UP(ns) ((((ns) * `CORE_CLK_MHZ) + 999) / 1000 < 1 ? 1 : \
  (((ns) * `CORE_CLK_MHZ) + 999) / 1000)

`endif

//--- hw/flash_pm_pkg.sv
// Types shared by the power sequencer modules
package flash_pm_pkg;
  typedef enum logic [2:0] {
    PM_STANDBY,
    PM_SLEEP_ENTRY,
    PM_SLEEP,
    PM_SLEEP_EXIT,
    PM_DEEP_ENTRY,
    PM_DEEP,
    PM_DEEP_EXIT
  } power_state_e;
  typedef logic [15:0] status_word_t;
  typedef logic [7:0] opcode_t;
endpackage

//--- hw/spi_link_if.sv
// Signals between the link-clock front end and the core sequencer
`timescale 1ns/1ps
interface spi_link_if;
  flash_pm_pkg::opcode_t op_byte;
  logic op_full;
  logic aligned;
  logic op_seq;
  flash_pm_pkg::status_word_t status_word;
  logic read_allow;
  modport core (
    input op_byte,
    input op_full,
    input aligned,
    input op_seq,
    output status_word,
    output read_allow
  );
  modport link (
    output op_byte,
    output op_full,
    output aligned,
    output op_seq,
    input status_word,
    input read_allow
  );
endinterface

//--- hw/spi_link_shifter.sv
// Serial-clock front end: opcode capture and status streaming
`timescale 1ns/1ps
`include "flash_pm_regs.svh"
module spi_link_shifter (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_rst_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  spi_link_if.link lnk
);
  logic [2:0] bit_in_byte_r;
  logic past_op_r;
  logic [6:0] shift_r;
  logic stream_r;
  logic [3:0] stream_idx_r;
  logic [15:0] stat_s1_r;
  logic [15:0] stat_s2_r;
  logic [15:0] stat_s3_r;
  logic [15:0] stat_hold_r;
  logic allow_s1_r;
  logic allow_s2_r;
  logic [7:0] op_now;

  assign op_now = {shift_r, i_si};

  // Core-side levels: status through three flops, read allow through two; bits settle during the opcode byte
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_s1_r <= `STAT_RESET;
      stat_s2_r <= `STAT_RESET;
      stat_s3_r <= `STAT_RESET;
      allow_s1_r <= 1'b0;
      allow_s2_r <= 1'b0;
    end else begin
      stat_s1_r <= lnk.status_word;
      stat_s2_r <= stat_s1_r;
      stat_s3_r <= stat_s2_r;
      allow_s1_r <= lnk.read_allow;
      allow_s2_r <= allow_s1_r;
    end
  end

  // Word taken only when two samples agree, so a torn word is never streamed
  // Limitation: flags toggling faster than the serial clock hold the last agreed word
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_hold_r <= `STAT_RESET;
    end else if (stat_s2_r == stat_s3_r) begin
      stat_hold_r <= stat_s3_r;
    end
  end

  // Frame-scoped state, cleared by deselect since the clock stops between frames
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_in_byte_r <= 3'h0;
      past_op_r <= 1'b0;
      shift_r <= 7'h00;
      stream_r <= 1'b0;
      stream_idx_r <= 4'h0;
    end else begin
      bit_in_byte_r <= bit_in_byte_r + 3'h1;
      shift_r <= op_now[6:0];
      if (!past_op_r && bit_in_byte_r == 3'h7) begin
        past_op_r <= 1'b1;
        stream_r <= (op_now == `OPC_STATUS_READ) && allow_s2_r;
      end
      if (stream_r) begin
        stream_idx_r <= stream_idx_r + 4'h1;
      end
    end
  end

  // Results held after the frame; read by the core only after deselect
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lnk.op_byte <= 8'h00;
      lnk.op_full <= 1'b0;
      lnk.aligned <= 1'b0;
      lnk.op_seq <= 1'b0;
    end else begin
      lnk.aligned <= (bit_in_byte_r == 3'h7);
      if (!past_op_r && bit_in_byte_r == 3'h7) begin
        lnk.op_byte <= op_now;
        lnk.op_full <= 1'b1;
        lnk.op_seq <= ~lnk.op_seq;
      end else if (!past_op_r && bit_in_byte_r == 3'h0) begin
        lnk.op_full <= 1'b0;
      end
    end
  end

  // Data changes on the falling edge; released at once on deselect
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else begin
      o_so <= stat_hold_r[4'hf - stream_idx_r];
      o_so_oe_n <= ~stream_r;
    end
  end
endmodule

//--- hw/flash_status_power_modes.sv
// Status flag assembly and power mode sequencer for a serial flash front end
// Overview of operation
// - Compare mismatch flag is one after a compare finding any differing bit.
// - Status carries a fixed four-bit legacy capacity code.
// - Protection flag shows sector protection active, by software or pin.
// - Page-size flag shows binary 512-byte or standard 528-byte pages.
// - Failure flag set on bad erase or program, refreshed every operation.
// - Aborted erase or program leaves the failure flag clear.
// - Lockdown-allowed flag is one until lockdown gets disabled, then zero.
// - Per-buffer suspend flag set; commands modifying that buffer blocked.
// - Erase-halted flag is one while any erase is suspended.
// - Standby whenever deselected and no internal operation runs.
// - In sleep every command except resume is ignored, status read too.
// - Opcode B9h then deselect enters sleep within entry time.
// - Short opcode or unaligned deselect aborts entry, staying in standby.
// - Sleep and deep sleep commands ignored while program or erase runs.
// - Opcode ABh then deselect returns to standby within resume time.
// - Short or unaligned resume aborts and the device stays asleep.
// - After reset the device starts in standby.
// - Opcode 79h enters deep sleep; then all commands are ignored.
// - Entering deep sleep discards buffer contents.
// - A long enough select pulse wakes deep sleep; exit within exit time.
// - Operations started before deep sleep exit finishes are ignored.
// - Status read D7h streams two bytes repeatedly, released on deselect.
// - Status bytes carry the flags at their fixed bit positions.
`timescale 1ns/1ps
`include "flash_pm_regs.svh"
module flash_status_power_modes #(
  parameter int unsigned TIMER_W = 16,
  parameter int unsigned SLEEP_ENTRY_CYC = `NS_TO_CYC_DN(`SLEEP_ENTRY_TIME_NS),
  parameter int unsigned SLEEP_EXIT_CYC = `NS_TO_CYC_DN(`SLEEP_EXIT_TIME_NS),
  parameter int unsigned DEEP_ENTRY_CYC = `NS_TO_CYC_DN(`DEEP_SLEEP_ENTRY_TIME_NS),
  parameter int unsigned DEEP_EXIT_CYC = `NS_TO_CYC_DN(`DEEP_SLEEP_EXIT_TIME_NS),
  parameter int unsigned WAKE_PULSE_CYC = `NS_TO_CYC_UP(`WAKE_PULSE_WIDTH_NS),
  // Arbitrary value, not tied to any real part
  parameter logic [3:0] CAPACITY_CODE = 4'h5
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_link_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  input wire logic i_op_busy,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  input wire logic i_op_aborted,
  input wire logic i_compare_done,
  input wire logic i_compare_diff,
  input wire logic i_protect_active,
  input wire logic i_page_binary,
  input wire logic i_lockdown_disabled,
  input wire logic i_prog_hold_buf1_flag,
  input wire logic i_prog_hold_buf2_flag,
  input wire logic i_erase_halted_flag,
  input wire logic i_buf1_write_req,
  input wire logic i_buf2_write_req,
  output logic o_buf1_write_ok,
  output logic o_buf2_write_ok,
  output logic o_cmd_enable,
  output logic o_standby,
  output logic o_sleep,
  output logic o_deep_sleep,
  output logic o_buffers_discard
);
  localparam logic [TIMER_W-1:0] SLEEP_ENTRY_LD = TIMER_W'(SLEEP_ENTRY_CYC - 1);
  localparam logic [TIMER_W-1:0] SLEEP_EXIT_LD = TIMER_W'(SLEEP_EXIT_CYC - 1);
  localparam logic [TIMER_W-1:0] DEEP_ENTRY_LD = TIMER_W'(DEEP_ENTRY_CYC - 1);
  localparam logic [TIMER_W-1:0] DEEP_EXIT_LD = TIMER_W'(DEEP_EXIT_CYC - 1);
  localparam logic [TIMER_W-1:0] WAKE_MIN = TIMER_W'(WAKE_PULSE_CYC);
  localparam int unsigned NUM_BUF = 2;

  spi_link_if lnk ();

  flash_pm_pkg::power_state_e state_r;
  flash_pm_pkg::power_state_e state_nxt;
  flash_pm_pkg::power_state_e frame_state_r;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] timer_nxt;
  logic [TIMER_W-1:0] low_cnt_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic cs_fall;
  logic cs_rise;
  logic frame_good;
  logic compare_diff_r;
  logic fail_flag_r;
  flash_pm_pkg::status_word_t status_r;
  logic discard_nxt;
  logic op_seq_seen_r;
  logic [NUM_BUF-1:0] buf_req;
  logic [NUM_BUF-1:0] buf_hold;
  logic [NUM_BUF-1:0] buf_ok;

  spi_link_shifter u_link (
    .i_sclk(i_link_sclk),
    .i_cs_n(i_cs_n),
    .i_rst_n(i_rst_n),
    .i_si(i_si),
    .o_so(o_so),
    .o_so_oe_n(o_so_oe_n),
    .lnk(lnk.link)
  );

  // Chip select into the core clock; first flop feeds only the second
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      cs_s1_r <= i_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
    end
  end

  assign cs_fall = cs_d_r & ~cs_s2_r;
  assign cs_rise = ~cs_d_r & cs_s2_r;

  // Link results are static once the serial clock has stopped at deselect
  assign frame_good = lnk.op_full & lnk.aligned & (lnk.op_seq != op_seq_seen_r);

  // A bare select pulse leaves the last opcode standing; only a fresh one counts
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_seq_seen_r <= 1'b0;
    end else if (cs_rise) begin
      op_seq_seen_r <= lnk.op_seq;
    end
  end

  // State seen at frame start; frames begun during a transition are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_state_r <= flash_pm_pkg::PM_STANDBY;
    end else if (cs_fall) begin
      frame_state_r <= state_r;
    end
  end

  // Select low time, saturating, for the deep sleep wake pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_r <= '0;
    end else if (cs_fall) begin
      low_cnt_r <= TIMER_W'(1);
    end else if (!cs_s2_r && low_cnt_r != '1) begin
      low_cnt_r <= low_cnt_r + TIMER_W'(1);
    end
  end

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    discard_nxt = 1'b0;
    case (state_r)
      flash_pm_pkg::PM_STANDBY: begin
        if (cs_rise && frame_state_r == flash_pm_pkg::PM_STANDBY && frame_good &&
            !i_op_busy) begin
          if (lnk.op_byte == `OPC_SLEEP_ENTER) begin
            state_nxt = flash_pm_pkg::PM_SLEEP_ENTRY;
            timer_nxt = SLEEP_ENTRY_LD;
          end else if (lnk.op_byte == `OPC_DEEP_ENTER) begin
            state_nxt = flash_pm_pkg::PM_DEEP_ENTRY;
            timer_nxt = DEEP_ENTRY_LD;
          end
        end
      end
      flash_pm_pkg::PM_SLEEP_ENTRY: begin
        if (timer_r == '0) begin
          state_nxt = flash_pm_pkg::PM_SLEEP;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      flash_pm_pkg::PM_SLEEP: begin
        // Anything but a clean resume leaves the device asleep
        if (cs_rise && frame_state_r == flash_pm_pkg::PM_SLEEP && frame_good &&
            lnk.op_byte == `OPC_SLEEP_RESUME) begin
          state_nxt = flash_pm_pkg::PM_SLEEP_EXIT;
          timer_nxt = SLEEP_EXIT_LD;
        end
      end
      flash_pm_pkg::PM_SLEEP_EXIT: begin
        if (timer_r == '0) begin
          state_nxt = flash_pm_pkg::PM_STANDBY;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      flash_pm_pkg::PM_DEEP_ENTRY: begin
        if (timer_r == '0) begin
          state_nxt = flash_pm_pkg::PM_DEEP;
          discard_nxt = 1'b1;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      flash_pm_pkg::PM_DEEP: begin
        // Opcode contents ignored; only the pulse width matters
        if (cs_rise && frame_state_r == flash_pm_pkg::PM_DEEP &&
            low_cnt_r >= WAKE_MIN) begin
          state_nxt = flash_pm_pkg::PM_DEEP_EXIT;
          timer_nxt = DEEP_EXIT_LD;
        end
      end
      flash_pm_pkg::PM_DEEP_EXIT: begin
        if (timer_r == '0) begin
          state_nxt = flash_pm_pkg::PM_STANDBY;
        end else begin
          timer_nxt = timer_r - TIMER_W'(1);
        end
      end
      default: begin
        state_nxt = flash_pm_pkg::PM_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= flash_pm_pkg::PM_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_r <= '0;
    end else begin
      timer_r <= timer_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_buffers_discard <= 1'b0;
    end else begin
      o_buffers_discard <= discard_nxt;
    end
  end

  // Mode outputs, each from its own flop
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_enable <= 1'b0;
    end else begin
      o_cmd_enable <= (state_nxt == flash_pm_pkg::PM_STANDBY);
    end
  end

  // Busy counts as active, so standby waits for the operation to end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_standby <= 1'b0;
    end else begin
      o_standby <= (state_nxt == flash_pm_pkg::PM_STANDBY) && cs_s2_r &&
                   !i_op_busy;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sleep <= 1'b0;
    end else begin
      o_sleep <= (state_nxt == flash_pm_pkg::PM_SLEEP);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_deep_sleep <= 1'b0;
    end else begin
      o_deep_sleep <= (state_nxt == flash_pm_pkg::PM_DEEP);
    end
  end

  assign buf_req = {i_buf2_write_req, i_buf1_write_req};
  assign buf_hold = {i_prog_hold_buf2_flag, i_prog_hold_buf1_flag};

  // Buffer writes blocked while the owning program is suspended
  for (genvar g = 0; g < NUM_BUF; g++) begin : g_buf
    logic ok_r;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ok_r <= 1'b0;
      end else begin
        ok_r <= buf_req[g] && !buf_hold[g] &&
                (state_r == flash_pm_pkg::PM_STANDBY);
      end
    end
    assign buf_ok[g] = ok_r;
  end

  assign o_buf1_write_ok = buf_ok[0];
  assign o_buf2_write_ok = buf_ok[1];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      compare_diff_r <= 1'b0;
    end else if (i_compare_done) begin
      compare_diff_r <= i_compare_diff;
    end
  end

  // Refreshed on every completion; an abort clears rather than sets
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fail_flag_r <= 1'b0;
    end else if (i_op_done) begin
      fail_flag_r <= i_op_fail && !i_op_aborted;
    end
  end

  // Status snapshot, rebuilt every cycle so each pass shows fresh data
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_r <= `STAT_RESET;
    end else begin
      status_r[`B1_READY] <= !i_op_busy;
      status_r[`B1_COMPARE] <= compare_diff_r;
      status_r[`B1_CAP_HI:`B1_CAP_LO] <= CAPACITY_CODE;
      status_r[`B1_PROTECT] <= i_protect_active;
      status_r[`B1_PAGE_BIN] <= i_page_binary;
      status_r[`B2_READY] <= !i_op_busy;
      status_r[`B2_RSVD6] <= 1'b0;
      status_r[`B2_FAIL] <= fail_flag_r;
      status_r[`B2_RSVD4] <= 1'b0;
      status_r[`B2_LOCK_OK] <= !i_lockdown_disabled;
      status_r[`B2_HOLD_BUF2] <= i_prog_hold_buf2_flag;
      status_r[`B2_HOLD_BUF1] <= i_prog_hold_buf1_flag;
      status_r[`B2_ERASE_HALT] <= i_erase_halted_flag;
    end
  end

  // Bits cross as separate levels; a read may mix two adjacent snapshots
  assign lnk.status_word = status_r;
  assign lnk.read_allow = (state_r == flash_pm_pkg::PM_STANDBY);
endmodule

//--- bench/flash_status_power_modes_assertions.sv
// Concurrent checks on the power sequencer ports
`timescale 1ns/1ps
module flash_status_power_modes_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_op_busy,
  input wire logic i_buf1_write_req,
  input wire logic i_buf2_write_req,
  input wire logic i_prog_hold_buf1_flag,
  input wire logic i_prog_hold_buf2_flag,
  input wire logic o_so_oe_n,
  input wire logic o_buf1_write_ok,
  input wire logic o_buf2_write_ok,
  input wire logic o_cmd_enable,
  input wire logic o_standby,
  input wire logic o_sleep,
  input wire logic o_deep_sleep,
  input wire logic o_buffers_discard
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_sleep_quiet;
    o_sleep |-> !o_cmd_enable && !o_standby && !o_deep_sleep;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep with commands open");
  property p_no_answer;
    (o_sleep || o_deep_sleep) |-> o_so_oe_n;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("output driven while asleep");
  property p_deep_quiet;
    o_deep_sleep |-> !o_cmd_enable && !o_standby && !o_buf1_write_ok && !o_buf2_write_ok;
  endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("deep sleep not quiet");
  property p_discard_deep;
    o_buffers_discard |-> ##[0:2] o_deep_sleep;
  endproperty
  a_discard_deep: assert property (p_discard_deep) else $error("discard without deep");
  property p_discard_pulse;
    o_buffers_discard |=> !o_buffers_discard;
  endproperty
  a_discard_pulse: assert property (p_discard_pulse) else $error("discard too long");
  property p_standby_idle;
    o_standby |-> !$past(i_op_busy);
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("standby while busy");
  property p_wr1;
    o_buf1_write_ok |-> $past(i_buf1_write_req) && !$past(i_prog_hold_buf1_flag);
  endproperty
  a_wr1: assert property (p_wr1) else $error("buffer one write let through");
  property p_wr2;
    o_buf2_write_ok |-> $past(i_buf2_write_req) && !$past(i_prog_hold_buf2_flag);
  endproperty
  a_wr2: assert property (p_wr2) else $error("buffer two write let through");
  property p_release;
    i_cs_n |-> o_so_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output held after deselect");

  c_sleep: cover property ($rose(o_sleep));
  c_deep: cover property ($rose(o_deep_sleep));
  c_hold: cover property (i_buf2_write_req && i_prog_hold_buf2_flag);
endmodule

bind flash_status_power_modes flash_status_power_modes_checker chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_op_busy(i_op_busy),
  .i_buf1_write_req(i_buf1_write_req), .i_buf2_write_req(i_buf2_write_req),
  .i_prog_hold_buf1_flag(i_prog_hold_buf1_flag),
  .i_prog_hold_buf2_flag(i_prog_hold_buf2_flag), .o_so_oe_n(o_so_oe_n),
  .o_buf1_write_ok(o_buf1_write_ok), .o_buf2_write_ok(o_buf2_write_ok),
  .o_cmd_enable(o_cmd_enable), .o_standby(o_standby), .o_sleep(o_sleep),
  .o_deep_sleep(o_deep_sleep), .o_buffers_discard(o_buffers_discard));

//--- bench/host_spi_model.sv
// Host serial master model, mode 0, clock parked low between frames
`timescale 1ns/1ps
module host_spi_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
                       output logic oe_seen);
    logic [31:0] sh;
    sh = tx;
    rx = '0;
    oe_seen = 1'b0;
    #1.7;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_si = sh[31];
      sh = sh << 1;
      #62.5;
      o_sclk = 1'b1;
      rx = {rx[30:0], i_so};
      oe_seen = oe_seen | ~i_so_oe_n;
      #62.5;
      o_sclk = 1'b0;
    end
    #62.5;
    o_cs_n = 1'b1;
    // Released line flips so a stale bit never looks valid
    o_si = ~o_si;
    #25;
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for status flags and power modes
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] CAP = 4'h5;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sclk, cs_n, si, so, so_oe_n, so_line, oe_seen;
  logic float_q = 1'b0;
  logic busy = 0, done = 0, fail = 0, abrt = 0, cdone = 0, cdiff = 0;
  logic prot = 0, pbin = 0, ldis = 0, h1 = 0, h2 = 0, ehalt = 0, wr1 = 0, wr2 = 0;
  logic ok1, ok2, cmd_en, standby, sleep, deep, disc;
  logic [31:0] rx;
  int error_cnt = 0;
  int n_tests = 0;
  int discard_cnt = 0;

  initial forever #2.5 i_core_clk = ~i_core_clk;
  // Undriven output line toggles so it never reads as data
  always @(posedge i_core_clk) float_q <= ~float_q;
  always @(posedge i_core_clk) begin
    if (disc === 1'b1) begin
      discard_cnt++;
    end
  end
  assign so_line = so_oe_n ? float_q : so;

  host_spi_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line),
    .i_so_oe_n(so_oe_n));

  flash_status_power_modes #(.SLEEP_ENTRY_CYC(4), .SLEEP_EXIT_CYC(4), .DEEP_ENTRY_CYC(4),
    .DEEP_EXIT_CYC(16), .WAKE_PULSE_CYC(2), .CAPACITY_CODE(CAP)) dut_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_link_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n), .i_op_busy(busy), .i_op_done(done),
    .i_op_fail(fail), .i_op_aborted(abrt), .i_compare_done(cdone), .i_compare_diff(cdiff),
    .i_protect_active(prot), .i_page_binary(pbin), .i_lockdown_disabled(ldis),
    .i_prog_hold_buf1_flag(h1), .i_prog_hold_buf2_flag(h2), .i_erase_halted_flag(ehalt),
    .i_buf1_write_req(wr1), .i_buf2_write_req(wr2), .o_buf1_write_ok(ok1),
    .o_buf2_write_ok(ok2), .o_cmd_enable(cmd_en), .o_standby(standby), .o_sleep(sleep),
    .o_deep_sleep(deep), .o_buffers_discard(disc));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic frm(input logic [31:0] tx, input int n);
    host_u.frame(tx, n, rx, oe_seen);
    cyc(30);
  endtask
  task automatic op_end(input logic f, input logic a);
    cyc(1);
    fail <= f;
    abrt <= a;
    done <= 1'b1;
    cdone <= 1'b1;
    cyc(1);
    done <= 1'b0;
    cdone <= 1'b0;
    cyc(4);
  endtask
  function automatic logic [15:0] stat(input logic rdy, input logic cmp, input logic f);
    return {rdy, cmp, CAP, prot, pbin, rdy, 1'b0, f, 1'b0, ~ldis, h2, h1, ehalt};
  endfunction
  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    finish_test;
  end

  initial begin
    cyc(8);
    i_rst_n <= 1'b1;
    cyc(6);
    check({sleep, deep, standby, cmd_en}, 4'b0011);
    prot <= 1'b1;
    pbin <= 1'b1;
    h1 <= 1'b1;
    ehalt <= 1'b1;
    cdiff <= 1'b1;
    op_end(1'b1, 1'b0);
    frm({8'hd7, 24'h0}, 40);
    check(rx, {2{stat(1'b1, 1'b1, 1'b1)}});
    // Second pass: flags moved, busy, aborted operation after a failed one
    {prot, pbin, h1, h2, ehalt, ldis, cdiff} <= 7'h0c;
    busy <= 1'b1;
    wr1 <= 1'b1;
    wr2 <= 1'b1;
    op_end(1'b1, 1'b1);
    frm({8'hd7, 24'h0}, 24);
    check(rx[15:0], stat(1'b0, 1'b0, 1'b0));
    check({ok1, ok2}, 2'b10);
    frm({8'hb9, 24'h0}, 8);
    check({sleep, deep}, 2'b00);
    busy <= 1'b0;
    cyc(4);
    frm({8'hb9, 24'h0}, 7);
    check({sleep, deep, standby}, 3'b001);
    frm({8'hb9, 24'h0}, 12);
    check({sleep, deep, standby}, 3'b001);
    frm({8'hb9, 24'h0}, 16);
    check({sleep, deep, standby, cmd_en, ok1, ok2}, 6'h20);
    frm({8'hd7, 24'h0}, 40);
    check(oe_seen, 1'b0);
    frm({8'hab, 24'h0}, 7);
    check({sleep, standby}, 2'b10);
    frm({8'hab, 24'h0}, 12);
    check({sleep, standby}, 2'b10);
    frm({8'hab, 24'hff0000}, 16);
    check({sleep, deep, standby}, 3'b001);
    frm({8'h79, 24'h0}, 8);
    check({sleep, deep, standby}, 3'b010);
    check(discard_cnt, 1);
    // A select pulse of at least WAKE_PULSE_CYC cycles wakes deep sleep; the status opcode in it is not answered
    frm({8'hd7, 24'h0}, 40);
    check(oe_seen, 1'b0);
    check({sleep, deep, standby}, 3'b001);
    frm({8'h79, 24'h0}, 8);
    check({sleep, deep}, 2'b01);
    // Wake with a dummy byte, then reselect before the exit has finished
    host_u.frame(32'h0, 8, rx, oe_seen);
    frm({8'hb9, 24'h0}, 8);
    check({sleep, deep, standby}, 3'b001);
    // One long status read that sees the operation finish between passes
    busy <= 1'b1;
    fork
      host_u.frame({8'hd7, 24'h0}, 40, rx, oe_seen);
      begin
        cyc(400);
        busy <= 1'b0;
      end
    join
    check(rx, {stat(1'b0, 1'b0, 1'b0), stat(1'b1, 1'b0, 1'b0)});
    finish_test;
  end
endmodule
